//--- fcns_pkg.sv
// constants for the name-server registration and loop timer block
package fcns_pkg;

	// ***********************************************************
	// clock and timing
	// ***********************************************************
	localparam int unsigned CLK_HZ         = 25000000;
	localparam int unsigned TICK_US        = 1000;
	localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000000 * TICK_US;
	localparam int unsigned AL_TIME_MS     = 15;
	localparam int unsigned LIS_HOLD_MS    = 1;
	localparam int unsigned RT_TOV_MS      = 100;
	localparam int unsigned ED_TOV_MS      = 2000;
	localparam int unsigned ELS_PRIV_MS    = 4000;
	localparam int unsigned RA_FABRIC_MS   = 10000;
	localparam int unsigned RR_TOV_MS      = 2000;
	localparam int unsigned LP_TOV_MS      = 2000;
	localparam int unsigned N_INIT         = 4;

	// ***********************************************************
	// common transport request
	// ***********************************************************
	localparam logic [23:0] NAME_SERVER_ID = 24'hfffffc;
	localparam logic [7:0]  CT_REVISION    = 8'h01;
	localparam logic [7:0]  CT_OPTIONS     = 8'h00;
	localparam logic [7:0]  SVC_TYPE_DIR   = 8'hfc;
	localparam logic [7:0]  SVC_SUB_NAME   = 8'h02;
	localparam logic [15:0] CMD_REG_TYPES  = 16'h0217;
	localparam logic [15:0] RSP_REJECT     = 16'h8001;
	localparam logic [15:0] RSP_ACCEPT     = 16'h8002;
	localparam logic [7:0]  FRAME_TYPE_CT  = 8'h20;
	localparam logic [7:0]  RCTL_REQUEST   = 8'h02;
	localparam logic [7:0]  RCTL_REPLY     = 8'h03;
	localparam logic [5:0]  REQ_LEN        = 6'd52;
	localparam logic [5:0]  RSP_LEN        = 6'd16;
	localparam logic [5:0]  POS_CMD_HI     = 6'd8;
	localparam logic [5:0]  POS_CMD_LO     = 6'd9;
	localparam logic [5:0]  POS_REASON     = 6'd13;
	localparam logic [5:0]  POS_EXPL       = 6'd14;
	localparam logic [5:0]  POS_VENDOR     = 6'd15;
	localparam logic [5:0]  POS_SID        = 6'd17;
	localparam logic [5:0]  POS_TYPE_MAP   = 6'd22;
	localparam logic [7:0]  TYPE_MAP_SCSI  = 8'h01;
	localparam logic [5:0]  POS_SVC_TYPE   = 6'd4;
	localparam logic [5:0]  POS_SVC_SUB    = 6'd5;
	localparam logic [5:0]  POS_OPTIONS    = 6'd6;

	// ***********************************************************
	// reject reason and explanation codes
	// ***********************************************************
	localparam logic [7:0] RSN_INV_CMD     = 8'h01;
	localparam logic [7:0] RSN_INV_VER     = 8'h02;
	localparam logic [7:0] RSN_LOGICAL     = 8'h03;
	localparam logic [7:0] RSN_INV_SIZE    = 8'h04;
	localparam logic [7:0] RSN_BUSY        = 8'h05;
	localparam logic [7:0] RSN_PROTOCOL    = 8'h07;
	localparam logic [7:0] RSN_UNABLE      = 8'h09;
	localparam logic [7:0] RSN_NOT_SUPP    = 8'h0b;
	localparam logic [7:0] RSN_VENDOR      = 8'hff;
	localparam logic [7:0] EXP_NOTREG_MAX  = 8'h0a;
	localparam logic [7:0] EXP_DENIED      = 8'h10;
	localparam logic [7:0] EXP_DB_EMPTY    = 8'h12;
	localparam logic [7:0] LIP_FAIL_CODE   = 8'hf8;

	// ***********************************************************
	// register map (word indices, one address step per register)
	// ***********************************************************
	localparam logic [3:0] ADDR_CTRL       = 4'h0;
	localparam logic [3:0] ADDR_STATUS     = 4'h1;
	localparam logic [3:0] ADDR_RESULT     = 4'h2;
	localparam logic [3:0] ADDR_PORT_ID    = 4'h3;
	localparam logic [3:0] ADDR_TIMEOUTS   = 4'h4;
	localparam int unsigned CTRL_START     = 0;
	localparam int unsigned CTRL_FABRIC    = 1;
	localparam int unsigned CTRL_PUBLIC    = 2;
	localparam int unsigned CTRL_SEQ_ARM   = 3;
	localparam int unsigned CTRL_ELS_ARM   = 4;
	localparam int unsigned CTRL_LP_ARM    = 5;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

	typedef enum logic [2:0]
	{
		REG_IDLE = 3'b000,
		REG_SEND = 3'b001,
		REG_WAIT = 3'b010,
		REG_RECV = 3'b011,
		REG_DONE = 3'b100
	} reg_state_t;

endpackage

//--- fcns_port.sv
// name-server registration framer, loop timers and frame delimiter handling
// ***********************************************************
// ***********************************************************
module fcns_port
	import fcns_pkg::*;
(
	// clock, reset, enable
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	// register bus
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic      [1:0]  response,
	// login and loop events (same clock)
	input  wire logic        login_done,
	input  wire logic        sync_lost,
	input  wire logic        lis_rx,
	input  wire logic        arb_start,
	input  wire logic        arb_won,
	// outbound request byte stream
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	output logic             tx_sof,
	output logic             tx_eof,
	output logic      [23:0] tx_dest_id,
	output logic      [7:0]  tx_frame_type,
	output logic      [7:0]  tx_rctl,
	input  wire logic        tx_ready,
	// inbound reply byte stream
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid,
	input  wire logic        rx_sof,
	input  wire logic [7:0]  rx_frame_type,
	input  wire logic [7:0]  rx_rctl,
	// frame delimiter checks
	input  wire logic        frm_done,
	input  wire logic        frm_bad_delim,
	input  wire logic        frm_is_data,
	input  wire logic        cdb_rsvd_bad,
	// per initiator recovery
	input  wire logic [N_INIT-1:0] init_login,
	input  wire logic [N_INIT-1:0] init_auth,
	// loop actions
	output logic             send_lip_f8,
	output logic      [7:0]  lip_code,
	output logic             lis_forward,
	output logic             al_timeout,
	output logic             abort_exchange,
	output logic             cdb_reject,
	output logic      [N_INIT-1:0] init_logout
);

	// ***********************************************************
	// registers and millisecond tick
	// ***********************************************************
	logic [31:0]  ctrl_reg;
	logic [23:0]  port_id_reg;
	logic [15:0]  tick_cnt_reg;
	logic         tick;
	logic [31:0]  bus_rd_next;
	logic         bus_hit;
	logic         start_pulse;
	logic [4:0]   tmo_reg;
	logic [7:0]   fail_cnt_reg;
	logic         ok_reg;
	logic         rej_reg;
	logic [7:0]   reason_reg;
	logic [7:0]   expl_reg;
	logic [7:0]   vendor_reg;
	logic [15:0]  rsp_code_reg;
	logic         rsn_known;
	logic         exp_known;
	logic         seq_exp;
	logic         lp_exp;
	logic         al_exp;

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			tick_cnt_reg <= '0;
			tick         <= 1'b0;
		end
		else if (clk_en)
		begin
			tick <= (tick_cnt_reg == 16'(TICK_CYCLES - 1));
			if (tick_cnt_reg == 16'(TICK_CYCLES - 1))
				tick_cnt_reg <= '0;
			else
				tick_cnt_reg <= tick_cnt_reg + 16'd1;
		end
	end

	// bus: one wait cycle, then answer
	assign bus_hit     = (read || write) && waitrequest == 1'b0;
	assign start_pulse = bus_hit && write && address == ADDR_CTRL && writedata[CTRL_START];

	always_comb
	begin
		case (address)
			ADDR_CTRL:     bus_rd_next = ctrl_reg;
			ADDR_STATUS:   bus_rd_next = {16'h0, 1'b0, rsn_known, exp_known,
			                  8'(fail_cnt_reg[4:0]), rej_reg, ok_reg, 3'b0};
			ADDR_RESULT:   bus_rd_next = {rsp_code_reg[7:0], reason_reg, expl_reg, vendor_reg};
			ADDR_PORT_ID:  bus_rd_next = {8'h0, port_id_reg};
			ADDR_TIMEOUTS: bus_rd_next = {27'h0, tmo_reg};
			default:       bus_rd_next = 32'h0;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			waitrequest <= 1'b1;
			readdata    <= '0;
			response    <= 2'b00;
			ctrl_reg    <= CTRL_RESET;
			port_id_reg <= '0;
		end
		else if (clk_en)
		begin
			waitrequest <= !((read || write) && waitrequest);
			if ((read || write) && waitrequest)
			begin
				readdata <= read ? bus_rd_next : 32'h0;
				response <= (address > ADDR_TIMEOUTS) ? 2'b10 : 2'b00;
			end
			if (bus_hit && write && address == ADDR_CTRL)
				ctrl_reg <= {writedata[31:1], 1'b0};
			if (bus_hit && write && address == ADDR_PORT_ID)
				port_id_reg <= writedata[23:0];
		end
	end

	// ***********************************************************
	// registration sequencer
	// ***********************************************************
	reg_state_t   state_reg;
	logic [5:0]   idx_reg;
	logic         pending_reg;
	logic [7:0]   req_byte;
	logic [15:0]  wait_ms_reg;
	logic [15:0]  els_limit;

	// fabric profile uses one 10 s timer, private waits 4 s
	assign els_limit = ctrl_reg[CTRL_FABRIC] ? 16'(RA_FABRIC_MS) : 16'(ELS_PRIV_MS);

	always_comb
	begin
		req_byte = 8'h00;
		case (idx_reg)
			6'd0:         req_byte = CT_REVISION;
			POS_SVC_TYPE: req_byte = SVC_TYPE_DIR;
			POS_SVC_SUB:  req_byte = SVC_SUB_NAME;
			POS_OPTIONS:  req_byte = CT_OPTIONS;
			POS_CMD_HI:   req_byte = CMD_REG_TYPES[15:8];
			POS_CMD_LO:   req_byte = CMD_REG_TYPES[7:0];
			POS_SID:      req_byte = port_id_reg[23:16];
			6'd18:        req_byte = port_id_reg[15:8];
			6'd19:        req_byte = port_id_reg[7:0];
			POS_TYPE_MAP: req_byte = TYPE_MAP_SCSI;
			default:      req_byte = 8'h00;
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			state_reg     <= REG_IDLE;
			idx_reg       <= '0;
			pending_reg   <= 1'b0;
			tx_data       <= '0;
			tx_valid      <= 1'b0;
			tx_sof        <= 1'b0;
			tx_eof        <= 1'b0;
			tx_dest_id    <= '0;
			tx_frame_type <= '0;
			tx_rctl       <= '0;
			wait_ms_reg   <= '0;
			ok_reg        <= 1'b0;
			rej_reg       <= 1'b0;
			reason_reg    <= '0;
			expl_reg      <= '0;
			vendor_reg    <= '0;
			rsp_code_reg  <= '0;
			tmo_reg       <= '0;
		end
		else if (clk_en)
		begin
			// clear first, so a same-cycle set below wins
			if (bus_hit && write && address == ADDR_TIMEOUTS)
				tmo_reg <= tmo_reg & ~writedata[4:0];
			if (login_done || start_pulse)
				pending_reg <= 1'b1;
			case (state_reg)
				REG_IDLE:
				begin
					if (pending_reg && ctrl_reg[CTRL_PUBLIC])
					begin
						pending_reg <= login_done || start_pulse;
						state_reg   <= REG_SEND;
						idx_reg     <= '0;
						ok_reg      <= 1'b0;
						rej_reg     <= 1'b0;
					end
				end
				REG_SEND:
				begin
					if (!tx_valid || tx_ready)
					begin
						tx_valid      <= 1'b1;
						tx_data       <= req_byte;
						tx_sof        <= (idx_reg == 6'd0);
						tx_eof        <= (idx_reg == REQ_LEN - 6'd1);
						tx_dest_id    <= NAME_SERVER_ID;
						tx_frame_type <= FRAME_TYPE_CT;
						tx_rctl       <= RCTL_REQUEST;
						if (idx_reg == REQ_LEN - 6'd1)
						begin
							state_reg <= REG_WAIT;
							idx_reg   <= '0;
						end
						else
							idx_reg <= idx_reg + 6'd1;
					end
				end
				REG_WAIT, REG_RECV:
				begin
					if (tx_valid && tx_ready)
					begin
						tx_valid <= 1'b0;
						tx_sof   <= 1'b0;
						tx_eof   <= 1'b0;
					end
					if (tick)
						wait_ms_reg <= wait_ms_reg + 16'd1;
					if (rx_valid && rx_frame_type == FRAME_TYPE_CT && rx_rctl == RCTL_REPLY)
					begin
						idx_reg   <= rx_sof ? 6'd1 : idx_reg + 6'd1;
						state_reg <= REG_RECV;
						// only code, reason, explanation and vendor bytes looked at
						case (rx_sof ? 6'd0 : idx_reg)
							POS_CMD_HI: rsp_code_reg[15:8] <= rx_data;
							POS_CMD_LO: rsp_code_reg[7:0]  <= rx_data;
							POS_REASON: reason_reg <= rx_data;
							POS_EXPL:   expl_reg   <= rx_data;
							POS_VENDOR: vendor_reg <= rx_data;
							default:    ;
						endcase
						if (!rx_sof && idx_reg == RSP_LEN - 6'd1)
							state_reg <= REG_DONE;
					end
					else if (wait_ms_reg >= els_limit)
					begin
						tmo_reg[0]  <= 1'b1;
						state_reg   <= REG_IDLE;
						wait_ms_reg <= '0;
					end
				end
				REG_DONE:
				begin
					wait_ms_reg <= '0;
					ok_reg      <= (rsp_code_reg == RSP_ACCEPT);
					rej_reg     <= (rsp_code_reg == RSP_REJECT);
					state_reg   <= REG_IDLE;
				end
				default: state_reg <= REG_IDLE;
			endcase
			if (state_reg != REG_WAIT && state_reg != REG_RECV)
				wait_ms_reg <= '0;
			if (seq_exp)
				tmo_reg[1] <= 1'b1;
			if (lp_exp)
				tmo_reg[2] <= 1'b1;
			if (al_exp)
				tmo_reg[3] <= 1'b1;
			if (|init_logout)
				tmo_reg[4] <= 1'b1;
		end
	end

	// reason and explanation classification
	always_comb
	begin
		case (reason_reg)
			RSN_INV_CMD, RSN_INV_VER, RSN_LOGICAL, RSN_INV_SIZE, RSN_BUSY,
			RSN_PROTOCOL, RSN_UNABLE, RSN_NOT_SUPP, RSN_VENDOR: rsn_known = 1'b1;
			default: rsn_known = 1'b0;
		endcase
		exp_known = (expl_reg <= EXP_NOTREG_MAX) ||
			(expl_reg >= EXP_DENIED && expl_reg <= EXP_DB_EMPTY);
	end

	// ***********************************************************
	// loop timers
	// ***********************************************************
	logic [15:0] sync_ms_reg;
	logic [15:0] seq_ms_reg;
	logic [15:0] lp_ms_reg;
	logic [15:0] al_ms_reg;

	assign seq_exp = ctrl_reg[CTRL_SEQ_ARM] && seq_ms_reg >= 16'(ED_TOV_MS);
	assign lp_exp  = ctrl_reg[CTRL_LP_ARM] && lp_ms_reg >= 16'(LP_TOV_MS);
	assign al_exp  = arb_start && al_ms_reg >= 16'(AL_TIME_MS);

	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			sync_ms_reg    <= '0;
			seq_ms_reg     <= '0;
			lp_ms_reg      <= '0;
			al_ms_reg      <= '0;
			send_lip_f8    <= 1'b0;
			lip_code       <= '0;
			lis_forward    <= 1'b0;
			al_timeout     <= 1'b0;
			abort_exchange <= 1'b0;
			cdb_reject     <= 1'b0;
			fail_cnt_reg   <= '0;
		end
		else if (clk_en)
		begin
			// continuous sync loss only
			sync_ms_reg <= !sync_lost ? 16'd0 : sync_ms_reg + {15'd0, tick};
			send_lip_f8 <= sync_lost && tick && sync_ms_reg == 16'(RT_TOV_MS - 1);
			lip_code    <= LIP_FAIL_CODE;
			if (sync_lost && tick && sync_ms_reg == 16'(RT_TOV_MS - 1))
				fail_cnt_reg <= fail_cnt_reg + 8'd1;
			// forwarded on the next cycle, well inside the hold time
			lis_forward <= lis_rx;
			seq_ms_reg <= (!ctrl_reg[CTRL_SEQ_ARM] || frm_done) ? 16'd0
				: seq_ms_reg + {15'd0, tick && !seq_exp};
			lp_ms_reg <= (!ctrl_reg[CTRL_LP_ARM] || lis_rx || frm_done) ? 16'd0
				: lp_ms_reg + {15'd0, tick && !lp_exp};
			al_ms_reg <= (!arb_start || arb_won) ? 16'd0
				: al_ms_reg + {15'd0, tick && !al_exp};
			al_timeout <= al_exp;
			// data frame aborts exchange; others dropped without action
			abort_exchange <= frm_done && frm_bad_delim && frm_is_data;
			// header reserved fields never examined, command block ones are
			cdb_reject <= frm_done && !frm_bad_delim && cdb_rsvd_bad;
		end
	end

	// ***********************************************************
	// per initiator recovery timers
	// ***********************************************************
	genvar gi;
	generate
		for (gi = 0; gi < N_INIT; gi++)
		begin : g_rr
			logic [15:0] rr_ms_reg;
			logic        rr_run_reg;
			always_ff @(posedge mclk)
			begin
				if (!resetn)
				begin
					rr_ms_reg       <= '0;
					rr_run_reg      <= 1'b0;
					init_logout[gi] <= 1'b0;
				end
				else if (clk_en)
				begin
					init_logout[gi] <= 1'b0;
					if (lis_rx && init_login[gi])
					begin
						rr_run_reg <= 1'b1;
						rr_ms_reg  <= '0;
					end
					else if (rr_run_reg && init_auth[gi])
						rr_run_reg <= 1'b0;
					else if (rr_run_reg && rr_ms_reg >= 16'(RR_TOV_MS))
					begin
						rr_run_reg      <= 1'b0;
						init_logout[gi] <= 1'b1;
					end
					else if (rr_run_reg && tick)
						rr_ms_reg <= rr_ms_reg + 16'd1;
				end
			end
		end
	endgenerate

endmodule

//--- fcns_port_assertions.sv
// concurrent checks on the ports of the name-server port block
module fcns_port_checker
	import fcns_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        resetn,
	// register bus
	input wire logic [3:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [1:0]  response,
	// request stream
	input wire logic [7:0]  tx_data,
	input wire logic        tx_valid,
	input wire logic        tx_sof,
	input wire logic [23:0] tx_dest_id,
	input wire logic [7:0]  tx_frame_type,
	input wire logic [7:0]  tx_rctl,
	input wire logic        tx_ready,
	// loop events and actions
	input wire logic        sync_lost,
	input wire logic        lis_rx,
	input wire logic        arb_start,
	input wire logic        send_lip_f8,
	input wire logic [7:0]  lip_code,
	input wire logic        lis_forward,
	input wire logic        al_timeout,
	// frame checks
	input wire logic        frm_done,
	input wire logic        frm_bad_delim,
	input wire logic        frm_is_data,
	input wire logic        cdb_rsvd_bad,
	input wire logic        abort_exchange,
	input wire logic        cdb_reject
);
	timeunit 1ns;
	timeprecision 1ps;
	// tick granularity allows one millisecond of slack
	localparam int unsigned LIP_MIN = (RT_TOV_MS - 1) * TICK_CYCLES;
	localparam int unsigned AL_MIN  = (AL_TIME_MS - 1) * TICK_CYCLES;
	logic [31:0] sync_cnt;
	logic [31:0] arb_cnt;

	always_ff @(posedge mclk)
	begin
		if (!resetn || !sync_lost)
			sync_cnt <= 32'h0;
		else
			sync_cnt <= sync_cnt + 32'h1;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn || !arb_start)
			arb_cnt <= 32'h0;
		else
			arb_cnt <= arb_cnt + 32'h1;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	sequence bus_take;
		(read || write) && waitrequest;
	endsequence
	sequence bad_data_frame;
		frm_done && frm_bad_delim && frm_is_data;
	endsequence

	bus_answer_a: assert property (bus_take |=> !waitrequest)
		else $error("bus request not answered after one wait cycle");
	answer_once_a: assert property (!waitrequest |=> waitrequest)
		else $error("answer held longer than one cycle");
	unmapped_resp_a: assert property (read && waitrequest && address > 4'h4
		|=> response == 2'b10 && readdata == 32'h0)
		else $error("unmapped read not refused");
	tx_route_a: assert property (tx_valid |-> tx_dest_id == 24'hfffffc
		&& tx_frame_type == 8'h20 && tx_rctl == 8'h02)
		else $error("request routing fields wrong");
	tx_hold_a: assert property (tx_valid && !tx_ready
		|=> tx_valid && $stable(tx_data) && $stable(tx_sof))
		else $error("request byte changed before accept");
	lis_fwd_a: assert property (lis_rx |=> lis_forward)
		else $error("loop init not forwarded in time");
	link_fail_a: assert property ($rose(send_lip_f8)
		|-> lip_code == 8'hf8 && sync_cnt >= LIP_MIN)
		else $error("link failure reset sent early or with wrong code");
	arb_time_a: assert property (al_timeout && arb_start |-> arb_cnt >= AL_MIN)
		else $error("arbitration timeout flagged early");
	data_abort_a: assert property (bad_data_frame |-> ##[1:4] abort_exchange)
		else $error("bad data frame did not abort exchange");
	nondata_drop_a: assert property (frm_done && frm_bad_delim && !frm_is_data
		|=> !abort_exchange[*3] ##0 !cdb_reject)
		else $error("bad non-data frame was acted on");
	cdb_check_a: assert property (frm_done && cdb_rsvd_bad && !frm_bad_delim
		&& !frm_is_data |-> ##[1:4] cdb_reject)
		else $error("reserved command block field not rejected");
endmodule

bind fcns_port fcns_port_checker u_chk (.mclk, .resetn, .address, .read, .write,
	.readdata, .waitrequest, .response, .tx_data, .tx_valid, .tx_sof, .tx_dest_id,
	.tx_frame_type, .tx_rctl, .tx_ready, .sync_lost, .lis_rx, .arb_start,
	.send_lip_f8, .lip_code, .lis_forward, .al_timeout, .frm_done, .frm_bad_delim,
	.frm_is_data, .cdb_rsvd_bad, .abort_exchange, .cdb_reject);

//--- fcns_port_tb_top.sv
// testbench for the name-server port block
module fcns_port_tb_top
	import fcns_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, resetn, read, write, waitrequest, login_done, sync_lost, lis_rx;
	logic arb_start, arb_won, tx_valid, tx_sof, tx_eof, tx_ready, rx_valid, rx_sof;
	logic frm_done, frm_bad_delim, frm_is_data, cdb_rsvd_bad, send_lip_f8, slow;
	logic lis_forward, al_timeout, abort_exchange, cdb_reject;
	logic [3:0]  address;
	logic [31:0] writedata, readdata, q;
	logic [1:0]  response, resp_q;
	logic [7:0]  tx_data, tx_frame_type, tx_rctl, rx_data, rx_frame_type, rx_rctl;
	logic [7:0]  lip_code, rsn, expl;
	logic [23:0] tx_dest_id;
	logic [15:0] rsp_code;
	logic [N_INIT-1:0] init_login, init_auth, init_logout;
	logic [7:0]  rsn_tab [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h09,
		8'h0b, 8'hff, 8'h06};
	logic [7:0]  expl_tab [10] = '{8'h00, 8'h01, 8'h07, 8'h0a, 8'h10, 8'h11, 8'h12,
		8'h0b, 8'h05, 8'h13};
	logic [2:0]  frm_tab [5] = '{3'b110, 3'b010, 3'b100, 3'b001, 3'b011};
	logic [1:0]  frm_exp [5] = '{2'b10, 2'b00, 2'b00, 2'b01, 2'b00};
	logic [1:0]  seen;
	int n_fail = 0;
	int n_tests = 0;

	fcns_port i_dut (.mclk, .resetn, .clk_en(1'b1), .address, .read, .write, .writedata,
		.readdata, .waitrequest, .response, .login_done, .sync_lost, .lis_rx, .arb_start,
		.arb_won, .tx_data, .tx_valid, .tx_sof, .tx_eof, .tx_dest_id, .tx_frame_type,
		.tx_rctl, .tx_ready, .rx_data, .rx_valid, .rx_sof, .rx_frame_type, .rx_rctl,
		.frm_done, .frm_bad_delim, .frm_is_data, .cdb_rsvd_bad, .init_login, .init_auth,
		.send_lip_f8, .lip_code, .lis_forward, .al_timeout, .abort_exchange, .cdb_reject,
		.init_logout);

	ns_model i_ns (.mclk, .resetn, .slow, .rsp_code, .rsn, .expl, .tx_data, .tx_valid,
		.tx_sof, .tx_eof, .tx_ready, .rx_data, .rx_valid, .rx_sof, .rx_frame_type, .rx_rctl);

	always #20 mclk = ~mclk;

	task automatic chk(input string what, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask

	// one bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= d;
		do
		begin
			@(posedge mclk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
		begin
			n_fail++;
			tally_and_finish();
		end
		q = readdata;
		resp_q = response;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wait_rsp;
		int n0;
		int n;
		n0 = i_ns.n_rsp;
		n = 0;
		while (i_ns.n_rsp == n0 && n < 3000)
		begin
			@(posedge mclk);
			n++;
		end
		if (n >= 3000)
		begin
			n_fail++;
			tally_and_finish();
		end
		repeat (3) @(posedge mclk);
	endtask

	function automatic logic [7:0] req_exp(int k);
		case (k)
			0: return 8'h01;
			4: return 8'hfc;
			5: return 8'h02;
			8: return 8'h02;
			9: return 8'h17;
			17: return 8'h0a;
			18: return 8'h0b;
			19: return 8'h0c;
			22: return 8'h01;
			default: return 8'h00;
		endcase
	endfunction

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge mclk);
		n_fail++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial
	begin
		{mclk, resetn, read, write, login_done, sync_lost, lis_rx, arb_start} = '0;
		{arb_won, frm_done, frm_bad_delim, frm_is_data, cdb_rsvd_bad, slow} = '0;
		{address, writedata, rsp_code, rsn, expl, init_login, init_auth} = '0;
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		bus(0, ADDR_CTRL, 0);
		chk("ctrl reset", q, CTRL_RESET);
		bus(0, ADDR_TIMEOUTS, 0);
		chk("timeouts reset", q, 0);
		bus(0, 4'h5, 0);
		chk("unmapped data", q, 0);
		chk("unmapped resp", resp_q, 2);
		$display("test registers done");
		// login while not a public loop device
		login_done <= 1'b1;
		@(posedge mclk);
		login_done <= 1'b0;
		repeat (100) @(posedge mclk);
		chk("frames private", i_ns.n_frm, 0);
		$display("test private loop done");
		bus(1, ADDR_PORT_ID, 32'h000a0b0c);
		// login taken while private stays queued until public
		rsp_code <= RSP_ACCEPT;
		bus(1, ADDR_CTRL, 32'h4);
		wait_rsp();
		chk("frames", i_ns.n_frm, 1);
		chk("req length", i_ns.n_req, 52);
		chk("eof index", i_ns.eof_at, 51);
		for (int k = 0; k < 52; k++)
			chk("req byte", i_ns.req[k], req_exp(k));
		bus(0, ADDR_STATUS, 0);
		chk("accepted", q[4:3], 2'b01);
		bus(0, ADDR_RESULT, 0);
		chk("accept result", q, 32'h0200003c);
		$display("test accept done");
		slow <= 1'b1;
		for (int i = 0; i < 10; i++)
		begin
			rsp_code <= RSP_REJECT;
			rsn <= rsn_tab[i];
			expl <= expl_tab[i];
			bus(1, ADDR_CTRL, 32'h5);
			wait_rsp();
			bus(0, ADDR_STATUS, 0);
			chk("rejected", q[4], 1'b1);
			chk("reason known", q[14], rsn_tab[i] inside {8'h01, 8'h02, 8'h03, 8'h04,
				8'h05, 8'h07, 8'h09, 8'h0b, 8'hff});
			chk("expl known", q[13], expl_tab[i] <= 8'h0a
				|| expl_tab[i] inside {8'h10, 8'h11, 8'h12});
			bus(0, ADDR_RESULT, 0);
			chk("reject result", q, {8'h01, rsn_tab[i], expl_tab[i], 8'h3c});
		end
		$display("test reject codes done");
		for (int i = 0; i < 5; i++)
		begin
			@(posedge mclk);
			{frm_is_data, frm_bad_delim, cdb_rsvd_bad} <= frm_tab[i];
			frm_done <= 1'b1;
			@(posedge mclk);
			frm_done <= 1'b0;
			seen = 2'b00;
			repeat (5)
			begin
				@(posedge mclk);
				seen = seen | {abort_exchange, cdb_reject};
			end
			chk("frame reaction", seen, frm_exp[i]);
		end
		$display("test delimiters done");
		lis_rx <= 1'b1;
		@(posedge mclk);
		lis_rx <= 1'b0;
		@(posedge mclk);
		chk("loop init forward", lis_forward, 1'b1);
		sync_lost <= 1'b1;
		arb_start <= 1'b1;
		init_login <= 4'hf;
		arb_won <= 1'b1;
		@(posedge mclk);
		arb_won <= 1'b0;
		seen = 2'b00;
		repeat (2000)
		begin
			@(posedge mclk);
			seen = seen | {send_lip_f8 | al_timeout, |init_logout};
		end
		init_auth <= 4'hf;
		@(posedge mclk);
		{init_auth, sync_lost, arb_start} <= '0;
		chk("early timer action", seen, 2'b00);
		bus(1, ADDR_TIMEOUTS, 32'h1f);
		bus(0, ADDR_TIMEOUTS, 0);
		chk("timeouts clear", q, 0);
		$display("test timers done");
		tally_and_finish();
	end
endmodule

//--- ns_model.sv
// name server model that takes the registration and answers it
module ns_model
	import fcns_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        resetn,
	// bench control
	input  wire logic        slow,
	input  wire logic [15:0] rsp_code,
	input  wire logic [7:0]  rsn,
	input  wire logic [7:0]  expl,
	// request stream
	input  wire logic [7:0]  tx_data,
	input  wire logic        tx_valid,
	input  wire logic        tx_sof,
	input  wire logic        tx_eof,
	output logic             tx_ready,
	// reply stream
	output logic      [7:0]  rx_data,
	output logic             rx_valid,
	output logic             rx_sof,
	output logic      [7:0]  rx_frame_type,
	output logic      [7:0]  rx_rctl
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] req [0:63];
	logic [7:0] rsp [0:15];
	logic       gap;
	int         n_req, n_rsp, n_frm, eof_at, idx;

	always @(posedge mclk)
	begin
		if (!resetn)
		begin
			tx_ready <= 1'b0;
			rx_valid <= 1'b0;
			rx_sof <= 1'b0;
			rx_data <= 8'h00;
			rx_frame_type <= 8'h00;
			rx_rctl <= 8'h00;
			gap <= 1'b0;
			idx = -1;
			n_req = 0;
			n_rsp = 0;
			n_frm = 0;
		end
		else
		begin
			tx_ready <= slow ? !tx_ready : 1'b1;
			gap <= slow && !gap;
			if (tx_valid && tx_ready)
			begin
				if (tx_sof)
				begin
					n_req = 0;
					n_frm++;
				end
				req[n_req[5:0]] = tx_data;
				if (tx_eof)
				begin
					eof_at = n_req;
					idx = 0;
					for (int j = 0; j < 16; j++)
						rsp[j] = 8'ha5 ^ 8'(j);
					rsp[8] = rsp_code[15:8];
					rsp[9] = rsp_code[7:0];
					rsp[13] = rsn;
					rsp[14] = expl;
					rsp[15] = 8'h3c;
				end
				n_req++;
			end
			if (idx >= 0 && !gap)
			begin
				rx_valid <= 1'b1;
				rx_sof <= idx == 0;
				rx_data <= rsp[idx];
				rx_frame_type <= 8'h20;
				rx_rctl <= 8'h03;
				idx++;
				if (idx == 16)
				begin
					idx = -1;
					n_rsp++;
				end
			end
			else
			begin
				// released lines carry no stale value
				rx_valid <= 1'b0;
				rx_sof <= 1'b0;
				rx_data <= ~rx_data;
				rx_frame_type <= ~rx_frame_type;
				rx_rctl <= ~rx_rctl;
			end
		end
	end
endmodule
